// file: design/watchdog_and_wakeup.v
// Notes on behaviour
// - wake on port A, interrupt or overflow
// - overflow wake resets only PC and SP
// - power-down flag: set halt, clear clear-op
// - expired flag set on every time-out
// - per-pin port A wake enable mask
// - port A wake resumes after halt
// - masked or stack-full interrupt resumes after halt
// - enabled interrupt with free stack is serviced
// - request pending at halt cannot wake
// - sleep wake waits for fast oscillator stable
// - one start-up counter for both oscillators
// - sub-clock from slow RC or crystal
// - divide sub-clock by two-power eight to eighteen
// - period codes map to ratio table
// - control reloads default except on time-out
// - two key values enable the watchdog
// - other key resets after debounce
// - key reset sets soft reset flag
// - sleep stops watchdog, idle keeps counting
// - normal time-out resets chip, sets flag
// - count cleared by key reset, clear, halt
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module watchdog_and_wakeup #(
	parameter PA_W     = 8,
	parameter INT_W    = 4,
	parameter FIXED_RC = 0
) (
	// clock and reset
	input  wire             CLK,
	input  wire             RESET,
	// register port
	input  wire [3:0]       ADDR,
	input  wire [7:0]       WDATA,
	input  wire             WR,
	input  wire             RD,
	output reg  [7:0]       RDATA,
	// oscillator pins
	input  wire             SLOW_RC_CLK,
	input  wire             SLOW_XTAL_CLK,
	input  wire             FAST_RC_CLK,
	input  wire             SUB_SEL_XTAL,
	output wire             FAST_OSC_EN,
	// core events and state
	input  wire             HALT_OP,
	input  wire             WDT_CLEAR_OP,
	input  wire             IDLE_SEL,
	input  wire             FSYS_ON,
	input  wire [INT_W-1:0] INT_REQ,
	input  wire [INT_W-1:0] INT_EN,
	input  wire             STACK_FULL,
	// port A pins
	input  wire [PA_W-1:0]  PORT_A,
	// mode and wake outputs
	output wire             CPU_RUN,
	output wire             SLEEP_MODE,
	output wire             IDLE_MODE,
	output reg              WAKE_RESUME,
	output reg              WAKE_INT_SERVICE,
	output reg              PC_SP_RESET,
	output reg              CHIP_RESET,
	output reg  [2:0]       WAKE_SOURCE
);

	localparam ST_RUN   = 2'd0;
	localparam ST_SLEEP = 2'd1;
	localparam ST_IDLE  = 2'd2;
	localparam ST_WARM  = 2'd3;
	localparam [7:0] MASK_RST = `WAKE_MASK_RST;

	reg [1:0]             state_q;
	reg [1:0]             act_q;
	reg                   idle_fast_q;
	reg [7:0]             control_q;
	reg [PA_W-1:0]        wake_mask_q;
	reg                   pdf_q;
	reg                   expired_q;
	reg                   soft_flag_q;
	reg                   fast_ok_q;
	reg                   slow_ok_q;
	reg [`WDT_CNT_W-1:0]  wdt_cnt_q;
	reg [1:0]             dbn_q;
	reg [10:0]            osc_cnt_q;
	reg [INT_W-1:0]       int_arm_q;
	reg [2:0]             rc_s_q;
	reg [2:0]             xt_s_q;
	reg [2:0]             fr_s_q;
	reg [1:0]             sel_s_q;
	reg [PA_W-1:0]        pa_s1_q;
	reg [PA_W-1:0]        pa_s2_q;
	reg [PA_W-1:0]        pa_s3_q;

	// pin synchronisers, third stage only for edges
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rc_s_q  <= 3'h0;
			xt_s_q  <= 3'h0;
			fr_s_q  <= 3'h0;
			sel_s_q <= 2'h0;
			// port A resets to its idle high level, so no false fall
			pa_s1_q <= {PA_W{1'b1}};
			pa_s2_q <= {PA_W{1'b1}};
			pa_s3_q <= {PA_W{1'b1}};
		end else begin
			rc_s_q  <= {rc_s_q[1:0], SLOW_RC_CLK};
			xt_s_q  <= {xt_s_q[1:0], SLOW_XTAL_CLK};
			fr_s_q  <= {fr_s_q[1:0], FAST_RC_CLK};
			sel_s_q <= {sel_s_q[0], SUB_SEL_XTAL};
			pa_s1_q <= PORT_A;
			pa_s2_q <= pa_s1_q;
			pa_s3_q <= pa_s2_q;
		end
	end

	wire rc_tick   = rc_s_q[1] & ~rc_s_q[2];
	wire xt_tick   = xt_s_q[1] & ~xt_s_q[2];
	wire fast_tick = fr_s_q[1] & ~fr_s_q[2];
	// the option pin is static; variants tie the source to the RC
	wire sub_xtal  = (FIXED_RC == 0) ? sel_s_q[1] : 1'b0;
	wire sub_tick  = sub_xtal ? xt_tick : rc_tick;

	// period select to ratio exponent
	function [4:0] ratio_shift;
		input [2:0] code;
		begin
			case (code)
			3'h0: ratio_shift = `SHIFT_CODE0;
			3'h1: ratio_shift = `SHIFT_CODE1;
			3'h2: ratio_shift = `SHIFT_CODE2;
			3'h3: ratio_shift = `SHIFT_CODE3;
			3'h4: ratio_shift = `SHIFT_CODE4;
			3'h5: ratio_shift = `SHIFT_CODE5;
			3'h6: ratio_shift = `SHIFT_CODE6;
			default: ratio_shift = `SHIFT_CODE7;
			endcase
		end
	endfunction

	wire [4:0]            wdt_shift = ratio_shift(control_q[`SEL_MSB:`SEL_LSB]);
	wire [4:0]            wdt_gap   = `WDT_SHIFT_MAX - wdt_shift;
	// the low n bits all set mark the last tick of a period
	wire [`WDT_CNT_W-1:0] wdt_term  = `WDT_CNT_ONES >> wdt_gap;
	wire [4:0]            key       = control_q[`KEY_MSB:`KEY_LSB];
	wire key_ok = (key == `KEY_ENABLE_A) || (key == `KEY_ENABLE_B);
	// the watchdog is stopped in sleep, so the count only moves here
	wire wdt_run = key_ok && ((state_q == ST_RUN) ||
		(state_q == ST_IDLE));
	wire wdt_ovf = wdt_run && sub_tick && (wdt_cnt_q == wdt_term);

	wire halt_go = HALT_OP && (state_q == ST_RUN);
	wire clr_go  = WDT_CLEAR_OP && (state_q == ST_RUN);
	wire soft_go = !key_ok && rc_tick &&
		(dbn_q == `DBN_EDGES - 2'd1);
	wire low_pwr = (state_q == ST_SLEEP) || (state_q == ST_IDLE);

	// wake sources, one cell per pin and per request bit
	genvar gi;
	wire [PA_W-1:0]       pa_hit;
	wire [INT_W-1:0]      int_live;
	generate
		for (gi = 0; gi < PA_W; gi = gi + 1) begin : g_pa_wake
			// falling edge seen after the sync, gated by its own bit
			assign pa_hit[gi] = pa_s3_q[gi] & ~pa_s2_q[gi] &
				wake_mask_q[gi];
		end
		for (gi = 0; gi < INT_W; gi = gi + 1) begin : g_int_wake
			// a request already high at halt stays disarmed
			assign int_live[gi] = INT_REQ[gi] & int_arm_q[gi];
		end
	endgenerate
	wire pa_fall  = |pa_hit;
	wire int_wake = |int_live;
	wire int_take = |(int_live & INT_EN) && !STACK_FULL;
	wire ovf_wake = wdt_ovf && low_pwr;
	wire wake     = low_pwr && (pa_fall || int_wake || ovf_wake);

	reg [1:0] act_d;
	always @* begin
		act_d = `ACT_RESUME;
		if (ovf_wake)
			act_d = `ACT_PCSP;
		else if (int_wake && int_take)
			act_d = `ACT_INT;
		else if (int_wake)
			act_d = `ACT_RESUME;
	end

	wire warm_done = (state_q == ST_WARM) && fast_tick &&
		(osc_cnt_q == `FAST_STARTUP - 11'd1);
	wire xt_done   = (state_q != ST_WARM) && !slow_ok_q && xt_tick &&
		(osc_cnt_q == `XTAL_STARTUP - 11'd1);

	// mode sequencing and wake actions
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_q          <= ST_WARM;
			act_q            <= `ACT_NONE;
			idle_fast_q      <= 1'b0;
			int_arm_q        <= {INT_W{1'b0}};
			WAKE_RESUME      <= 1'b0;
			WAKE_INT_SERVICE <= 1'b0;
			PC_SP_RESET      <= 1'b0;
			WAKE_SOURCE      <= 3'h0;
		end else begin
			WAKE_RESUME      <= 1'b0;
			WAKE_INT_SERVICE <= 1'b0;
			PC_SP_RESET      <= 1'b0;
			case (state_q)
			ST_RUN: begin
				if (halt_go) begin
					// snapshot requests: stale ones may not wake
					int_arm_q   <= ~INT_REQ;
					idle_fast_q <= FSYS_ON;
					state_q     <= IDLE_SEL ? ST_IDLE : ST_SLEEP;
				end
			end
			ST_SLEEP, ST_IDLE: begin
				if (wake) begin
					WAKE_SOURCE <= {ovf_wake, int_wake, pa_fall};
					if (state_q == ST_IDLE && idle_fast_q) begin
						// fast clock kept running, no start-up wait
						state_q          <= ST_RUN;
						WAKE_RESUME      <= (act_d == `ACT_RESUME);
						WAKE_INT_SERVICE <= (act_d == `ACT_INT);
						PC_SP_RESET      <= (act_d == `ACT_PCSP);
					end else begin
						state_q <= ST_WARM;
						act_q   <= act_d;
					end
				end
			end
			ST_WARM: begin
				// the action is held until the core may run again
				if (warm_done) begin
					state_q          <= ST_RUN;
					act_q            <= `ACT_NONE;
					WAKE_RESUME      <= (act_q == `ACT_RESUME);
					WAKE_INT_SERVICE <= (act_q == `ACT_INT);
					PC_SP_RESET      <= (act_q == `ACT_PCSP);
				end
			end
			default: state_q <= ST_RUN;
			endcase
		end
	end

	// shared start-up counter: fast osc in warm-up, crystal otherwise
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			osc_cnt_q <= 11'h0;
			fast_ok_q <= 1'b0;
			slow_ok_q <= 1'b0;
		end else begin
			if (halt_go && !(IDLE_SEL && FSYS_ON)) begin
				osc_cnt_q <= 11'h0;
				fast_ok_q <= 1'b0;
			end else if (state_q == ST_WARM) begin
				if (warm_done) begin
					osc_cnt_q <= 11'h0;
					fast_ok_q <= 1'b1;
				end else if (fast_tick) begin
					osc_cnt_q <= osc_cnt_q + 11'd1;
				end
			end else if (!slow_ok_q) begin
				if (!sub_xtal) begin
					slow_ok_q <= 1'b1;
				end else if (xt_done) begin
					slow_ok_q <= 1'b1;
					osc_cnt_q <= 11'h0;
				end else if (xt_tick && low_pwr == 1'b0) begin
					// crystal count pauses while the core is halted
					osc_cnt_q <= osc_cnt_q + 11'd1;
				end
			end
		end
	end

	// a time-out in run resets the chip; in low power it only wakes
	wire run_timeout = wdt_ovf && !low_pwr;

	// watchdog count and key debounce
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wdt_cnt_q  <= {`WDT_CNT_W{1'b0}};
			dbn_q      <= 2'h0;
			CHIP_RESET <= 1'b0;
		end else begin
			CHIP_RESET <= soft_go || run_timeout;
			if (soft_go || clr_go || halt_go || wdt_ovf)
				wdt_cnt_q <= {`WDT_CNT_W{1'b0}};
			else if (wdt_run && sub_tick)
				wdt_cnt_q <= wdt_cnt_q + 18'd1;
			// a valid key restarts the debounce from zero
			if (key_ok || soft_go)
				dbn_q <= 2'h0;
			else if (rc_tick)
				dbn_q <= dbn_q + 2'd1;
		end
	end

	wire wr_ctl  = WR && (ADDR == `OFS_WDT_CONTROL);
	wire wr_stat = WR && (ADDR == `OFS_STATUS);
	wire wr_mask = WR && (ADDR == `OFS_WAKE_MASK);

	// registers and flags; a hardware set beats a clear
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			control_q   <= `WDT_CONTROL_RST;
			wake_mask_q <= MASK_RST[PA_W-1:0];
			pdf_q       <= 1'b0;
			expired_q   <= 1'b0;
			soft_flag_q <= 1'b0;
		end else begin
			// a time-out warm reset leaves the control untouched
			if (soft_go)
				control_q <= `WDT_CONTROL_RST;
			else if (wr_ctl)
				control_q <= WDATA;
			if (wr_mask)
				wake_mask_q <= WDATA[PA_W-1:0];
			if (clr_go)
				pdf_q <= 1'b0;
			if (halt_go)
				pdf_q <= 1'b1;
			if (clr_go || halt_go)
				expired_q <= 1'b0;
			if (wdt_ovf)
				expired_q <= 1'b1;
			// software may only clear the soft reset flag
			if (wr_stat && !WDATA[`ST_SOFTRST_BIT])
				soft_flag_q <= 1'b0;
			if (soft_go)
				soft_flag_q <= 1'b1;
		end
	end

	// read data one cycle after the strobe
	reg [7:0] rd_d;
	always @* begin
		rd_d = 8'h00;
		case (ADDR)
		`OFS_WDT_CONTROL: rd_d = control_q;
		`OFS_STATUS: begin
			rd_d[`ST_PDF_BIT]     = pdf_q;
			rd_d[`ST_EXPIRED_BIT] = expired_q;
			rd_d[`ST_SOFTRST_BIT] = soft_flag_q;
			rd_d[`ST_FASTOK_BIT]  = fast_ok_q;
			rd_d[`ST_SLOWOK_BIT]  = slow_ok_q;
		end
		`OFS_WAKE_MASK: rd_d[PA_W-1:0] = wake_mask_q;
		default: rd_d = 8'h00;
		endcase
	end

	// zero outside the answer cycle, so read buses can be ored
	always @(posedge CLK or posedge RESET) begin
		if (RESET)
			RDATA <= 8'h00;
		else if (RD)
			RDATA <= rd_d;
		else
			RDATA <= 8'h00;
	end

	assign CPU_RUN     = (state_q == ST_RUN);
	assign SLEEP_MODE  = (state_q == ST_SLEEP);
	assign IDLE_MODE   = (state_q == ST_IDLE);
	// idle with fsys on keeps the fast oscillator alive
	assign FAST_OSC_EN = !(SLEEP_MODE || (IDLE_MODE && !idle_fast_q));

endmodule // watchdog_and_wakeup

// file: design/watchdog_defs.vh
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH
// register offsets
`define OFS_WDT_CONTROL    4'h0
`define OFS_STATUS         4'h1
`define OFS_WAKE_MASK      4'h2
// watchdog_control fields
`define KEY_MSB            7
`define KEY_LSB            3
`define SEL_MSB            2
`define SEL_LSB            0
`define WDT_CONTROL_RST    8'h53
`define KEY_ENABLE_A       5'h0a
`define KEY_ENABLE_B       5'h15
// status fields and wake mask reset
`define ST_PDF_BIT         0
`define ST_EXPIRED_BIT     1
`define ST_SOFTRST_BIT     2
`define ST_FASTOK_BIT      3
`define ST_SLOWOK_BIT      4
`define WAKE_MASK_RST      8'h00
// watchdog count
`define WDT_CNT_W          18
`define WDT_CNT_ONES       18'h3ffff
`define WDT_SHIFT_MAX      5'd18
`define SHIFT_CODE0        5'd8
`define SHIFT_CODE1        5'd10
`define SHIFT_CODE2        5'd12
`define SHIFT_CODE3        5'd14
`define SHIFT_CODE4        5'd15
`define SHIFT_CODE5        5'd16
`define SHIFT_CODE6        5'd17
`define SHIFT_CODE7        5'd18
// debounce and start-up, counted in oscillator edges
`define DBN_EDGES          2'd3
`define FAST_STARTUP       11'd16
`define XTAL_STARTUP       11'd1024
// wake action codes
`define ACT_NONE           2'd0
`define ACT_RESUME         2'd1
`define ACT_INT            2'd2
`define ACT_PCSP           2'd3
`endif

// file: verif/watchdog_monitor.sv
`timescale 1ns/1ps
module watchdog_monitor (
	// clock and reset
	input wire logic       CLK,
	input wire logic       RESET,
	// core events
	input wire logic       HALT_OP,
	input wire logic       IDLE_SEL,
	// mode and wake outputs
	input wire logic       CPU_RUN,
	input wire logic       SLEEP_MODE,
	input wire logic       IDLE_MODE,
	input wire logic       WAKE_RESUME,
	input wire logic       WAKE_INT_SERVICE,
	input wire logic       PC_SP_RESET,
	input wire logic       CHIP_RESET,
	input wire logic [2:0] WAKE_SOURCE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_one_action;
		$onehot0({WAKE_RESUME, WAKE_INT_SERVICE, PC_SP_RESET, CHIP_RESET});
	endproperty
	a_one_action: assert property (p_one_action)
		else $error("two wake actions at once");
	property p_chip_short;
		CHIP_RESET |=> !CHIP_RESET;
	endproperty
	a_chip_short: assert property (p_chip_short)
		else $error("chip reset longer than one cycle");
	property p_pcsp_src;
		PC_SP_RESET |-> WAKE_SOURCE[2] && CPU_RUN;
	endproperty
	a_pcsp_src: assert property (p_pcsp_src)
		else $error("pc and sp reset without overflow wake");
	property p_int_src;
		WAKE_INT_SERVICE |-> WAKE_SOURCE[1] && !WAKE_SOURCE[2];
	endproperty
	a_int_src: assert property (p_int_src)
		else $error("interrupt service without interrupt wake");
	property p_resume_run;
		WAKE_RESUME |-> CPU_RUN && !WAKE_SOURCE[2];
	endproperty
	a_resume_run: assert property (p_resume_run)
		else $error("resume pulse outside run");
	property p_halt_sleep;
		CPU_RUN && HALT_OP && !IDLE_SEL |=> SLEEP_MODE && !CPU_RUN;
	endproperty
	a_halt_sleep: assert property (p_halt_sleep)
		else $error("halt did not enter sleep");
	property p_halt_idle;
		CPU_RUN && HALT_OP && IDLE_SEL |=> IDLE_MODE && !SLEEP_MODE;
	endproperty
	a_halt_idle: assert property (p_halt_idle)
		else $error("halt did not enter idle");
	// start-up needs many fast edges, so run cannot follow sleep at once
	property p_sleep_warm;
		$fell(SLEEP_MODE) |-> !CPU_RUN [*8] ##[1:1000] CPU_RUN;
	endproperty
	a_sleep_warm: assert property (p_sleep_warm)
		else $error("sleep wake skipped oscillator start-up");
endmodule // watchdog_monitor
bind watchdog_and_wakeup watchdog_monitor u_mon (
	.CLK(CLK), .RESET(RESET), .HALT_OP(HALT_OP), .IDLE_SEL(IDLE_SEL),
	.CPU_RUN(CPU_RUN), .SLEEP_MODE(SLEEP_MODE), .IDLE_MODE(IDLE_MODE),
	.WAKE_RESUME(WAKE_RESUME), .WAKE_INT_SERVICE(WAKE_INT_SERVICE),
	.PC_SP_RESET(PC_SP_RESET), .CHIP_RESET(CHIP_RESET),
	.WAKE_SOURCE(WAKE_SOURCE));

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module tb_top;
	logic       clk, reset, wr, rd, halt_op, clr_op, idle_sel, fsys_on;
	logic       slow_rc, xtal, fast_rc, stack_full, fast_en, cpu_run;
	logic       sleep_m, idle_m, w_res, w_int, w_pcsp, w_chip;
	logic [3:0] addr, int_req, int_en;
	logic [7:0] wdata, port_a, rdata, rv;
	logic [2:0] wake_src;
	logic       sub_sel;
	int         err_total, samples_checked, n, c;
	watchdog_and_wakeup dut_u (
		.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .SLOW_RC_CLK(slow_rc), .SLOW_XTAL_CLK(xtal),
		.FAST_RC_CLK(fast_rc), .SUB_SEL_XTAL(sub_sel), .FAST_OSC_EN(fast_en),
		.HALT_OP(halt_op), .WDT_CLEAR_OP(clr_op), .IDLE_SEL(idle_sel),
		.FSYS_ON(fsys_on), .INT_REQ(int_req), .INT_EN(int_en),
		.STACK_FULL(stack_full), .PORT_A(port_a), .CPU_RUN(cpu_run),
		.SLEEP_MODE(sleep_m), .IDLE_MODE(idle_m), .WAKE_RESUME(w_res),
		.WAKE_INT_SERVICE(w_int), .PC_SP_RESET(w_pcsp),
		.CHIP_RESET(w_chip), .WAKE_SOURCE(wake_src));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// fast oscillator stands still while the block turns it off
	initial begin
		fast_rc = 0;
		forever #200 if (fast_en !== 1'b0) fast_rc = ~fast_rc;
	end
	initial begin
		slow_rc = 0;
		forever #800 slow_rc = ~slow_rc;
	end
	initial begin
		xtal = 0;
		forever #15259 xtal = ~xtal;
	end
	task stop_test;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		cyc(1);
		wr <= 1;
		addr <= a;
		wdata <= d;
		cyc(1);
		wr <= 0;
	endtask
	task rd_reg(input logic [3:0] a);
		cyc(1);
		rd <= 1;
		addr <= a;
		cyc(1);
		rd <= 0;
		#1 rv = rdata;
	endtask
	task op(input logic h, input logic idl, input logic fs);
		cyc(1);
		idle_sel <= idl;
		fsys_on <= fs;
		halt_op <= h;
		clr_op <= !h;
		cyc(1);
		halt_op <= 0;
		clr_op <= 0;
	endtask
	function logic ev(input int k);
		case (k)
			0: ev = w_res;
			1: ev = w_int;
			2: ev = w_pcsp;
			3: ev = w_chip;
			default: ev = cpu_run;
		endcase
	endfunction
	task wait_ev(input int k, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (ev(k) !== 1'b1 && n < lim);
		if (n >= lim) begin
			err_total++;
			$display("ERROR %0t wait ran out", $time);
			stop_test;
		end
	endtask
	task s_regs;
		rd_reg(`OFS_WDT_CONTROL);
		chk(rv, `WDT_CONTROL_RST);
		rd_reg(`OFS_WAKE_MASK);
		chk(rv, `WAKE_MASK_RST);
		wr_reg(4'hf, 8'hff);
		rd_reg(4'hf);
		chk(rv, 8'h00);
	endtask
	task s_port(input logic idl, input logic fs);
		wr_reg(`OFS_WAKE_MASK, 8'h01);
		op(1, idl, fs);
		port_a <= 8'hfd;
		cyc(10);
		chk({7'h0, idle_m | sleep_m}, 8'h01);
		chk({7'h0, fast_en}, {7'h0, fs});
		port_a <= 8'hfc;
		wait_ev(0, 400);
		chk({7'h0, n > 40 || fs}, 8'h01);
		chk({5'h0, wake_src}, 8'h01);
		port_a <= 8'hff;
		rd_reg(`OFS_STATUS);
		chk(rv & 8'h01, 8'h01);
		chk(rv & 8'h18, 8'h18);
		op(0, 0, 0);
		rd_reg(`OFS_STATUS);
		chk(rv & 8'h01, 8'h00);
	endtask
	task s_int;
		int_req <= 4'b0001;
		op(1, 1, 1);
		cyc(10);
		chk({7'h0, idle_m}, 8'h01);
		int_req <= 4'b0011;
		wait_ev(1, 20);
		chk({5'h0, wake_src}, 8'h02);
		int_req <= 4'b0000;
		stack_full <= 1;
		op(1, 1, 1);
		int_req <= 4'b0010;
		wait_ev(0, 20);
		chk({5'h0, wake_src}, 8'h02);
		int_req <= 4'b0000;
		stack_full <= 0;
	endtask
	// a tick is 16 clock cycles, clear phase adds one tick of slack
	task s_ovf;
		for (c = 0; c < 2; c++) begin
			wr_reg(`OFS_WDT_CONTROL, 8'h50 | c[7:0]);
			op(0, 0, 0);
			wait_ev(3, 20000);
			chk({7'h0, n > (4096 << 2 * c) - 40}, 8'h01);
			chk({7'h0, n < (4096 << 2 * c) + 40}, 8'h01);
			rd_reg(`OFS_STATUS);
			chk(rv & 8'h02, 8'h02);
		end
		wr_reg(`OFS_WDT_CONTROL, 8'h50);
		op(1, 1, 1);
		wait_ev(2, 6000);
		chk({5'h0, wake_src}, 8'h04);
		rd_reg(`OFS_STATUS);
		chk(rv & 8'h02, 8'h02);
		rd_reg(`OFS_WDT_CONTROL);
		chk(rv, 8'h50);
	endtask
	task s_key;
		wr_reg(`OFS_WDT_CONTROL, 8'h00);
		wait_ev(3, 100);
		chk({7'h0, n > 28}, 8'h01);
		rd_reg(`OFS_STATUS);
		chk(rv & 8'h04, 8'h04);
		rd_reg(`OFS_WDT_CONTROL);
		chk(rv, `WDT_CONTROL_RST);
	endtask
	// crystal ticks are far slower than the rc, so no time-out follows
	task s_src;
		sub_sel <= 1;
		wr_reg(`OFS_WDT_CONTROL, 8'h50);
		op(0, 0, 0);
		n = 0;
		repeat (5000) begin
			@(posedge clk);
			#1 if (w_chip !== 1'b0) n++;
		end
		chk({7'h0, n == 0}, 8'h01);
		sub_sel <= 0;
		wr_reg(`OFS_WDT_CONTROL, `WDT_CONTROL_RST);
	endtask
	initial begin
		{reset, wr, rd, halt_op, clr_op, idle_sel, fsys_on} = 7'h40;
		{stack_full, addr, int_req, int_en, wdata} = '0;
		sub_sel = 0;
		port_a = 8'hff;
		int_en = 4'b0010;
		cyc(20);
		reset <= 0;
		wait_ev(4, 500);
		s_regs;
		s_port(1, 1);
		s_port(1, 0);
		s_port(0, 0);
		s_int;
		s_ovf;
		s_key;
		s_src;
		stop_test;
	end
endmodule // tb_top
